// >>> logic/imb_pkg.sv
// Shared constants and types of the I2C master block
package imb_pkg;

  // ==========================================================
  // Register map, byte addresses on the Avalon-MM slave
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_BAUD = 5'h08;
  localparam logic [4:0] OFF_BUF  = 5'h0C;
  localparam logic [4:0] OFF_MODE = 5'h10;

  // ==========================================================
  // Field positions of control_reg_two
  localparam int C_START   = 0;
  localparam int C_RESTART = 1;
  localparam int C_STOP    = 2;
  localparam int C_RCV     = 3;
  localparam int C_ACK     = 4;
  localparam int C_ACKDT   = 5;
  localparam int C_ACKRX   = 6;
  localparam int CMD_W     = 5;

  // Field positions of port_status_reg
  localparam int S_START = 0;
  localparam int S_STOP  = 1;
  localparam int S_FULL  = 2;
  localparam int S_IRQ   = 3;
  localparam int S_COLL  = 4;
  localparam int S_WRITE_COLLISION_FLAG  = 5;
  localparam int S_BUSY  = 6;

  // Field positions of the mode register
  localparam int M_EN  = 0;
  localparam int M_SEL = 1;

  // ==========================================================
  // Values after reset and encodings
  localparam logic [6:0] BAUD_RST    = 7'h00;
  localparam logic [4:0] MODE_RST    = 5'h00;
  localparam logic [3:0] MODE_MASTER = 4'h8;
  localparam logic [1:0] PH_TWO      = 2'h1;
  localparam logic [1:0] PH_FOUR     = 2'h3;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_LAST_RX = 4'h7;

  // ==========================================================
  // Transfer kinds of the bit engine
  typedef enum logic [1:0] {XM_TX, XM_RX, XM_ACK} imb_xmode_t;

  // Bus sequencer states
  typedef enum logic [4:0] {
    ST_IDLE, ST_SWAIT, ST_SHOLD,
    ST_RLOW, ST_RSDAHI, ST_RSCLREL, ST_RHIGH, ST_RSDALOW,
    ST_BLOW, ST_BREL, ST_BHIGH,
    ST_PSDALOW, ST_PCNT1, ST_PSCLHI, ST_PCNT2, ST_PSDAHI, ST_PCNT3
  } imb_state_t;

endpackage : imb_pkg

// >>> logic/imb_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module imb_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // Pins idle high, so both stages reset high
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : imb_sync
`default_nettype wire

// >>> logic/imb_baud.sv
// Baud counter with quarter-phase decrement ticks
`timescale 1ns/1ps
`default_nettype none
module imb_baud #(
  parameter int CW = 7
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          reset,
  // Reload control
  input  wire logic          reload,
  input  wire logic [CW-1:0] reload_val,
  // Count state
  output logic      [CW-1:0] count_q,
  output logic               zero,
  output logic               tick
);
  logic [1:0] phase_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================
  // Four clocks per instruction cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) phase_q <= 2'h0;
    else phase_q <= phase_q + 2'h1;
  end

  assign tick = (phase_q == imb_pkg::PH_TWO) || (phase_q == imb_pkg::PH_FOUR);

  // Down count, holds at zero until reloaded
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) count_q <= '0;
    else if (reload) count_q <= reload_val;
    else if (tick && !zero) count_q <= count_q - 1'b1;
  end

  assign zero = (count_q == '0);

  // ==========================================================
  bc_hold_a: assert property (zero && !reload |=> zero)
    else $error("baud counter left zero without reload");
  bc_tick_a: assert property (tick |=> !tick ##1 tick)
    else $error("decrement ticks not every second clock");
  bc_dec_a: assert property (tick && !reload && !zero |=> count_q == $past(count_q) - 1'b1)
    else $error("baud counter missed a decrement");
endmodule : imb_baud
`default_nettype wire

// >>> logic/imb_i2c_master.sv
// I2C master sequencer with start, restart, stop and byte engine
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module imb_i2c_master (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // SCL pin
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  // SDA pin
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  imb_pkg::imb_state_t state_q, state_d;
  imb_pkg::imb_xmode_t xmode_q;
  logic [1:0]  pins_s;
  logic        scl_s, sda_s, scl_d1_q, sda_d1_q;
  logic        start_det, stop_det;
  logic        ack_q, req, wr_en, ctl_wr, buf_wr, buf_rd;
  logic [4:0]  addr;
  logic [31:0] rd_word;
  logic [6:0]  baud_q, bc_val, bc_count;
  logic [4:0]  mode_q, cmd_q;
  logic        master_on, busy, tx_go;
  logic        ack_data_q, ack_rx_q;
  logic [7:0]  buf_q, shreg_q;
  logic [3:0]  bit_cnt_q;
  logic        full_q, irq_q, coll_q, write_collision_flag_q, sseen_q, pseen_q;
  logic        scl_low_q, scl_low_d, sda_low_q, sda_low_d;
  logic        bc_reload, bc_zero, half_sel;
  logic        ev_done, ev_coll, ev_bit, bitval, last_bit;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Sticky flag update, hardware set wins over software clear
  function automatic logic flag_next(input logic old, input logic set, input logic clr);
    flag_next = set | (old & ~clr);
  endfunction : flag_next

  // ==========================================================
  // Pin sampling and bus condition detection
  imb_sync #(.W(2)) u_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .d       ({scl_i, sda_i}),
    .q       (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // Previous synchronised levels
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_d1_q <= scl_s;
      sda_d1_q <= sda_s;
    end
  end

  assign start_det = scl_s && scl_d1_q && sda_d1_q && !sda_s;
  assign stop_det  = scl_s && scl_d1_q && !sda_d1_q && sda_s;

  // Open-drain drive, low or released only
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;

  // ==========================================================
  // Baud counter
  assign bc_val = half_sel ? {1'b0, baud_q[5:0]} : baud_q;

  imb_baud #(.CW(7)) u_baud (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .reload     (bc_reload),
    .reload_val (bc_val),
    .count_q    (bc_count),
    .zero       (bc_zero),
    .tick       ()
  );

  // ==========================================================
  // Avalon-MM slave, one wait state on every access
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_q;
  assign addr            = {avs_address[4:2], 2'h0};
  assign wr_en           = avs_write & ack_q & avs_byteenable[0];
  assign ctl_wr          = wr_en && (addr == imb_pkg::OFF_CTRL);
  assign buf_wr          = wr_en && (addr == imb_pkg::OFF_BUF);
  assign buf_rd          = avs_read && ack_q && (addr == imb_pkg::OFF_BUF);

  assign master_on = mode_q[imb_pkg::M_EN] && (mode_q[imb_pkg::M_SEL +: 4] == imb_pkg::MODE_MASTER);
  assign busy      = (state_q != imb_pkg::ST_IDLE) || (cmd_q != '0);
  assign tx_go     = buf_wr && !busy && master_on;

  // Read data mux, unmapped words read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr)
      imb_pkg::OFF_CTRL: rd_word = {25'h0, ack_rx_q, ack_data_q, cmd_q};
      imb_pkg::OFF_STAT: rd_word = {25'h0, busy, write_collision_flag_q, coll_q, irq_q, full_q, pseen_q, sseen_q};
      imb_pkg::OFF_BAUD: rd_word = {25'h0, baud_q};
      imb_pkg::OFF_BUF:  rd_word = {24'h0, buf_q};
      imb_pkg::OFF_MODE: rd_word = {27'h0, mode_q};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // Handshake and registered read data
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) avs_readdata <= rd_word;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      baud_q     <= imb_pkg::BAUD_RST;
      mode_q     <= imb_pkg::MODE_RST;
      ack_data_q <= 1'b0;
    end else begin
      if (wr_en && addr == imb_pkg::OFF_BAUD) baud_q <= avs_writedata[6:0];
      if (wr_en && addr == imb_pkg::OFF_MODE) mode_q <= avs_writedata[4:0];
      if (ctl_wr) ack_data_q <= avs_writedata[imb_pkg::C_ACKDT];
    end
  end

  // Command bits, lowest set bit only, accepted only while idle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) cmd_q <= '0;
    else if (!master_on || ev_done || ev_coll) cmd_q <= '0;
    else if (ctl_wr && !busy) cmd_q <= avs_writedata[4:0] & (~avs_writedata[4:0] + 5'h01);
  end

  // ==========================================================
  // Bus sequencer
  always_comb begin
    if (xmode_q == imb_pkg::XM_ACK) bitval = ack_data_q;
    else if (xmode_q == imb_pkg::XM_TX && bit_cnt_q < imb_pkg::BIT_ACK) bitval = shreg_q[7];
    else bitval = 1'b1;
    if (xmode_q == imb_pkg::XM_ACK) last_bit = 1'b1;
    else if (xmode_q == imb_pkg::XM_TX) last_bit = (bit_cnt_q == imb_pkg::BIT_ACK);
    else last_bit = (bit_cnt_q == imb_pkg::BIT_LAST_RX);
  end

  always_comb begin
    state_d   = state_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    bc_reload = 1'b0;
    half_sel  = 1'b0;
    ev_done   = 1'b0;
    ev_coll   = 1'b0;
    ev_bit    = 1'b0;
    case (state_q)
      imb_pkg::ST_IDLE: begin
        if (tx_go || cmd_q[imb_pkg::C_RCV] || cmd_q[imb_pkg::C_ACK]) begin
          scl_low_d = 1'b1;
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_BLOW;
        end else if (cmd_q[imb_pkg::C_START]) begin
          if (!scl_s || !sda_s) ev_coll = 1'b1;
          else begin
            bc_reload = 1'b1;
            state_d   = imb_pkg::ST_SWAIT;
          end
        end else if (cmd_q[imb_pkg::C_RESTART]) begin
          scl_low_d = 1'b1;
          state_d   = imb_pkg::ST_RLOW;
        end else if (cmd_q[imb_pkg::C_STOP]) begin
          scl_low_d = 1'b1;
          sda_low_d = 1'b1;
          state_d   = imb_pkg::ST_PSDALOW;
        end
      end
      imb_pkg::ST_SWAIT: begin
        if (!scl_s || !sda_s) ev_coll = 1'b1;
        else if (bc_zero) begin
          sda_low_d = 1'b1;
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_SHOLD;
        end
      end
      imb_pkg::ST_SHOLD: begin
        if (bc_zero) begin
          ev_done = 1'b1;
          state_d = imb_pkg::ST_IDLE;
        end
      end
      imb_pkg::ST_RLOW: begin
        if (!scl_s) begin
          half_sel  = 1'b1;
          bc_reload = 1'b1;
          sda_low_d = 1'b0;
          state_d   = imb_pkg::ST_RSDAHI;
        end
      end
      imb_pkg::ST_RSDAHI: begin
        if (bc_zero) begin
          if (!sda_s) ev_coll = 1'b1;
          else begin
            scl_low_d = 1'b0;
            state_d   = imb_pkg::ST_RSCLREL;
          end
        end
      end
      imb_pkg::ST_RSCLREL: begin
        if (scl_s) begin
          if (!sda_s) ev_coll = 1'b1;
          else begin
            bc_reload = 1'b1;
            state_d   = imb_pkg::ST_RHIGH;
          end
        end
      end
      imb_pkg::ST_RHIGH: begin
        if (!scl_s || !sda_s) ev_coll = 1'b1;
        else if (bc_zero) begin
          sda_low_d = 1'b1;
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_RSDALOW;
        end
      end
      imb_pkg::ST_RSDALOW: begin
        if (bc_zero) begin
          ev_done = 1'b1;
          state_d = imb_pkg::ST_IDLE;
        end
      end
      imb_pkg::ST_BLOW: begin
        sda_low_d = ~bitval;
        if (bc_zero) begin
          scl_low_d = 1'b0;
          state_d   = imb_pkg::ST_BREL;
        end
      end
      imb_pkg::ST_BREL: begin
        if (scl_s) begin
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_BHIGH;
        end
      end
      imb_pkg::ST_BHIGH: begin
        if (bc_zero) begin
          ev_bit    = 1'b1;
          scl_low_d = 1'b1;
          if (last_bit) begin
            ev_done = 1'b1;
            state_d = imb_pkg::ST_IDLE;
          end else begin
            bc_reload = 1'b1;
            state_d   = imb_pkg::ST_BLOW;
          end
        end
      end
      imb_pkg::ST_PSDALOW: begin
        if (!sda_s) begin
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_PCNT1;
        end
      end
      imb_pkg::ST_PCNT1: begin
        if (bc_zero) begin
          scl_low_d = 1'b0;
          state_d   = imb_pkg::ST_PSCLHI;
        end
      end
      imb_pkg::ST_PSCLHI: begin
        if (scl_s) begin
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_PCNT2;
        end
      end
      imb_pkg::ST_PCNT2: begin
        if (bc_zero) begin
          sda_low_d = 1'b0;
          state_d   = imb_pkg::ST_PSDAHI;
        end
      end
      imb_pkg::ST_PSDAHI: begin
        if (sda_s && scl_s) begin
          bc_reload = 1'b1;
          state_d   = imb_pkg::ST_PCNT3;
        end
      end
      imb_pkg::ST_PCNT3: begin
        if (bc_zero) begin
          ev_done = 1'b1;
          state_d = imb_pkg::ST_IDLE;
        end
      end
      default: state_d = imb_pkg::ST_IDLE;
    endcase
    if (ev_coll || !master_on) begin
      state_d   = imb_pkg::ST_IDLE;
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
    end
  end

  // State and line drive
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q   <= imb_pkg::ST_IDLE;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
    end
  end

  // ==========================================================
  // Bit engine: shift register, bit count, transfer kind
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      xmode_q   <= imb_pkg::XM_TX;
      bit_cnt_q <= 4'h0;
      shreg_q   <= 8'h00;
    end else if (tx_go) begin
      xmode_q   <= imb_pkg::XM_TX;
      bit_cnt_q <= 4'h0;
      shreg_q   <= avs_writedata[7:0];
    end else if (state_q == imb_pkg::ST_IDLE && cmd_q[imb_pkg::C_RCV]) begin
      xmode_q   <= imb_pkg::XM_RX;
      bit_cnt_q <= 4'h0;
    end else if (state_q == imb_pkg::ST_IDLE && cmd_q[imb_pkg::C_ACK]) begin
      xmode_q   <= imb_pkg::XM_ACK;
      bit_cnt_q <= 4'h0;
    end else if (ev_bit) begin
      shreg_q   <= {shreg_q[6:0], sda_s};
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // Acknowledge seen after a sent byte
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) ack_rx_q <= 1'b0;
    else if (ev_bit && last_bit && xmode_q == imb_pkg::XM_TX) ack_rx_q <= sda_s;
  end

  // Data buffer and its full flag
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      buf_q  <= 8'h00;
      full_q <= 1'b0;
    end else begin
      if (tx_go) buf_q <= avs_writedata[7:0];
      else if (ev_bit && last_bit && xmode_q == imb_pkg::XM_RX) buf_q <= {shreg_q[6:0], sda_s};
      full_q <= flag_next(full_q, tx_go || (ev_bit && last_bit && xmode_q == imb_pkg::XM_RX),
                          buf_rd || (ev_bit && xmode_q == imb_pkg::XM_TX && bit_cnt_q == imb_pkg::BIT_LAST_RX));
    end
  end

  // Status flags, write one to clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_q   <= 1'b0;
      coll_q  <= 1'b0;
      write_collision_flag_q  <= 1'b0;
      sseen_q <= 1'b0;
      pseen_q <= 1'b0;
    end else begin
      irq_q   <= flag_next(irq_q, ev_done, wr_en && addr == imb_pkg::OFF_STAT && avs_writedata[imb_pkg::S_IRQ]);
      coll_q  <= flag_next(coll_q, ev_coll, wr_en && addr == imb_pkg::OFF_STAT && avs_writedata[imb_pkg::S_COLL]);
      write_collision_flag_q  <= flag_next(write_collision_flag_q, buf_wr && !tx_go, wr_en && addr == imb_pkg::OFF_STAT && avs_writedata[imb_pkg::S_WRITE_COLLISION_FLAG]);
      sseen_q <= flag_next(sseen_q, start_det, wr_en && addr == imb_pkg::OFF_STAT && avs_writedata[imb_pkg::S_START]);
      pseen_q <= flag_next(pseen_q, stop_det, wr_en && addr == imb_pkg::OFF_STAT && avs_writedata[imb_pkg::S_STOP]);
    end
  end

  // ==========================================================
  // Checks
  sequence s_hold_timeout;
    state_q == imb_pkg::ST_SHOLD && bc_zero && master_on;
  endsequence
  sequence s_rs_scl_low;
    state_q == imb_pkg::ST_RLOW && !scl_s && master_on;
  endsequence

  start_done_a: assert property (s_hold_timeout |=> !cmd_q[imb_pkg::C_START] && irq_q && sda_oe)
    else $error("start completion did not clear request or raise irq");
  rs_release_a: assert property (s_rs_scl_low |=> state_q == imb_pkg::ST_RSDAHI && !sda_oe && scl_oe)
    else $error("restart did not release SDA after SCL low");
  write_collision_flag_set_a: assert property (buf_wr && busy && !ev_bit |=> write_collision_flag_q && buf_q == $past(buf_q))
    else $error("write during sequence not rejected");
  ctl_block_a: assert property (ctl_wr && state_q inside {imb_pkg::ST_SWAIT, imb_pkg::ST_SHOLD, imb_pkg::ST_RLOW,
    imb_pkg::ST_RSDAHI, imb_pkg::ST_RSCLREL, imb_pkg::ST_RHIGH, imb_pkg::ST_RSDALOW} && !ev_done && !ev_coll
    |=> cmd_q == $past(cmd_q))
    else $error("control write accepted during start");
  start_coll_a: assert property (state_q == imb_pkg::ST_SWAIT && !scl_s |=> coll_q && state_q == imb_pkg::ST_IDLE && !sda_oe)
    else $error("start collision not handled");
  reload_wait_a: assert property (state_q inside {imb_pkg::ST_BREL, imb_pkg::ST_PSCLHI, imb_pkg::ST_RSCLREL} && !scl_s
    |-> !bc_reload)
    else $error("reload while SCL still low");
  ack_flag_a: assert property (state_q == imb_pkg::ST_BHIGH && bc_zero && xmode_q == imb_pkg::XM_TX && bit_cnt_q == 4'h8
    && master_on |=> ack_rx_q == $past(sda_s) && irq_q && scl_oe)
    else $error("ack not captured after ninth clock");
  one_cmd_a: assert property ($onehot0(cmd_q))
    else $error("more than one command active");
endmodule : imb_i2c_master
`default_nettype wire

// >>> test/imb_slave.sv
// Behavioural I2C slave that captures and acknowledges bytes and answers one read byte
`timescale 1ns/1ps
`default_nettype none
module imb_slave #(
  parameter logic [7:0] TX_BYTE = 8'h5A
) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // Open-drain pull, captured byte and acknowledge from the master
  output logic            ack_pull,
  output logic [7:0]      rx_byte,
  output logic            mack
);
  int   cnt  = 9;
  logic rd_q = 1'b0;
  initial ack_pull = 1'b0;
  initial mack = 1'b1;
  // A Start or Repeated Start opens a new byte
  always @(negedge sda) begin
    if (scl) cnt = 0;
  end
  // Bits taken MSB first on SCL rise
  always @(posedge scl) begin
    if (cnt < 8) rx_byte = {rx_byte[6:0], sda};
    if (cnt == 17) mack = sda;
    cnt++;
  end
  // SDA pulled for the ninth bit, then read data MSB first after a read address
  always @(negedge scl) begin
    if (cnt == 8) rd_q <= rx_byte[0];
    ack_pull <= (cnt == 8) || (rd_q && cnt >= 9 && cnt <= 16 && !TX_BYTE[16 - cnt]);
  end
endmodule : imb_slave
`default_nettype wire

// >>> test/imb_i2c_master_tb_top.sv
// Testbench of the I2C master: bus tasks, scenarios and verdict
`timescale 1ns/1ps
`default_nettype none
module imb_i2c_master_tb_top;
  // ==========================================================
  // Clock, bus and open-drain lines with pull-ups
  logic        ref_clk = 0, reset = 1, avs_read = 0, avs_write = 0, hold_scl = 0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, scl_o, scl_oe, sda_o, sda_oe, ack_pull, mack;
  localparam logic [7:0] RD_BYTE = 8'h5A;
  logic [7:0]  rx_byte;
  wire         scl = ~(scl_oe | hold_scl);
  wire         sda = ~(sda_oe | ack_pull);
  int          n_fail = 0, n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  imb_i2c_master dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe));
  imb_slave #(.TX_BYTE(RD_BYTE)) slv_u (.scl(scl), .sda(sda), .ack_pull(ack_pull), .rx_byte(rx_byte),
    .mack(mack));
  // ==========================================================
  // Verdict, comparison and bus tasks
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One access held until waitrequest drops
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= ~w;
    avs_address <= a;
    avs_writedata <= d;
    // Sampled on the rising edge; the write lands and read data is taken there
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_fail++;
      conclude();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Poll a status bit, then clear every write-one-to-clear flag after reading (the full flag stays set)
  task automatic wait_stat(input int b, output logic [31:0] s);
    int i;
    for (i = 0; i < 400; i++) begin
      bus(1'b0, imb_pkg::OFF_STAT, 32'h0);
      if (q[b] === 1'b1) break;
    end
    if (i == 400) begin
      n_fail++;
      conclude();
    end
    s = q;
    bus(1'b1, imb_pkg::OFF_STAT, 32'h3F);
  endtask : wait_stat
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    bus(1'b0, imb_pkg::OFF_BAUD, 32'h0);
    chk("baud", q, 32'(imb_pkg::BAUD_RST));
    bus(1'b0, imb_pkg::OFF_MODE, 32'h0);
    chk("mode", q, 32'(imb_pkg::MODE_RST));
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", q, 32'h0);
  endtask : t_reset
  task automatic t_start();
    logic [31:0] s;
    bus(1'b1, imb_pkg::OFF_MODE, {27'h0, imb_pkg::MODE_MASTER, 1'b1});
    bus(1'b1, imb_pkg::OFF_BAUD, 32'h3);
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h1);
    bus(1'b1, imb_pkg::OFF_BUF, 32'h55);
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h4);
    wait_stat(imb_pkg::S_IRQ, s);
    chk("start seen", 32'(s[imb_pkg::S_START]), 32'h1);
    chk("write_collision_flag", 32'(s[imb_pkg::S_WRITE_COLLISION_FLAG]), 32'h1);
    bus(1'b0, imb_pkg::OFF_CTRL, 32'h0);
    chk("ctrl cmds", 32'(q[4:0]), 32'h0);
    chk("sda held", 32'(sda), 32'h0);
  endtask : t_start
  task automatic t_byte(input logic [7:0] d);
    logic [31:0] s;
    bus(1'b1, imb_pkg::OFF_BUF, 32'(d));
    wait_stat(imb_pkg::S_IRQ, s);
    chk("byte on wire", 32'(rx_byte), 32'(d));
    bus(1'b0, imb_pkg::OFF_CTRL, 32'h0);
    chk("ack rx", 32'(q[imb_pkg::C_ACKRX]), 32'h0);
    chk("scl held", 32'(scl), 32'h0);
  endtask : t_byte
  task automatic t_restart();
    logic [31:0] s;
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h2);
    wait_stat(imb_pkg::S_IRQ, s);
    chk("rs seen", 32'(s[imb_pkg::S_START]), 32'h1);
    bus(1'b0, imb_pkg::OFF_CTRL, 32'h0);
    chk("rs clear", 32'(q[imb_pkg::C_RESTART]), 32'h0);
    chk("rs sda", 32'({scl, sda}), 32'h2);
  endtask : t_restart
  // Read one byte from the slave, then send the acknowledge bit
  task automatic t_recv();
    logic [31:0] s;
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h8);
    wait_stat(imb_pkg::S_IRQ, s);
    chk("rx full", 32'(s[imb_pkg::S_FULL]), 32'h1);
    bus(1'b0, imb_pkg::OFF_BUF, 32'h0);
    chk("rx data", q, 32'(RD_BYTE));
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h10);
    wait_stat(imb_pkg::S_IRQ, s);
    chk("ack sent", 32'(mack), 32'h0);
  endtask : t_recv
  task automatic t_stop();
    logic [31:0] s;
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h4);
    wait_stat(imb_pkg::S_IRQ, s);
    chk("stop seen", 32'(s[imb_pkg::S_STOP]), 32'h1);
    chk("lines free", 32'({scl, sda}), 32'h3);
    chk("drive level", 32'({scl_o, sda_o}), 32'h0);
  endtask : t_stop
  task automatic t_coll();
    logic [31:0] s;
    hold_scl <= 1'b1;
    bus(1'b1, imb_pkg::OFF_CTRL, 32'h1);
    wait_stat(imb_pkg::S_COLL, s);
    chk("abort sda", 32'(sda_oe), 32'h0);
    chk("abort busy", 32'(s[imb_pkg::S_BUSY]), 32'h0);
    hold_scl <= 1'b0;
  endtask : t_coll
  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_start();
    t_byte(8'hA0);
    t_restart();
    t_byte(8'hA1);
    t_recv();
    t_stop();
    t_coll();
    conclude();
  end
endmodule : imb_i2c_master_tb_top
`default_nettype wire
